// ==== verilog/fcp_pkg.sv ====
// package: register map, field positions and reset values of the four channel pwm
package fcp_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] FCP_OFF_CLOCK_JOIN = 8'h40;
    localparam logic [7:0] FCP_OFF_SEL_POL = 8'h41;
    localparam logic [7:0] FCP_OFF_ENABLE = 8'h42;
    localparam logic [7:0] FCP_OFF_PRESCALE = 8'h43;
    localparam logic [7:0] FCP_OFF_SCALE_LO = 8'h44;
    localparam logic [7:0] FCP_OFF_SCNT_LO = 8'h45;
    localparam logic [7:0] FCP_OFF_SCALE_HI = 8'h46;
    localparam logic [7:0] FCP_OFF_SCNT_HI = 8'h47;
    localparam logic [7:0] FCP_OFF_COUNT = 8'h48;
    localparam logic [7:0] FCP_OFF_PERIOD = 8'h4c;
    localparam logic [7:0] FCP_OFF_DUTY = 8'h50;
    localparam logic [7:0] FCP_OFF_ALIGN = 8'h54;
    localparam logic [7:0] FCP_OFF_PORT_DIR = 8'h55;
    localparam logic [7:0] FCP_OFF_PORT_DATA = 8'h56;
    // field positions in the clock and join register
    localparam int FCP_JOIN_UPPER_BIT = 7;
    localparam int FCP_JOIN_LOWER_BIT = 6;
    localparam int FCP_PRESCALE_A_LSB = 3;
    localparam int FCP_PRESCALE_B_LSB = 0;
    // field positions in the select and polarity register
    localparam int FCP_SCALED_SEL_LSB = 4;
    localparam int FCP_START_LEVEL_LSB = 0;
    // reset values
    localparam logic [7:0] FCP_RST_ZERO = 8'h00;
    localparam logic [7:0] FCP_RST_PERIOD = 8'hff;
    localparam logic [7:0] FCP_RST_DUTY = 8'hff;
endpackage : fcp_pkg

// ==== verilog/fcp_pwm.sv ====
// four channel pwm with pair joining, prescalers, scaled clocks and double buffering
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - four 8-bit channels, or pairs joined into 16-bit channels
// - each channel has counter, period and duty; duty from 0 to 100 percent
// - each output left-aligned or center-aligned
// - enabled channel: new period or duty wait for rollover or disable
// - disabled channel: writes go straight to buffer and active latch
// - counter write clears counter and loads pending period and duty
// - software can read each channel counter
// - enabled channel overrides general purpose port control of its pin
// - upper join: ch2 high byte, ch3 low byte, ch3 clock, ch2 pin
// - lower join: ch0 high byte, ch1 low byte, ch1 clock, ch0 pin
// - clock a prescale code 0..7 divides module clock by 1..128
// - clock b prescale code uses the same power of two encoding
// - ch0 and ch1 select: 0 clock a, 1 scaled clock lower
// - ch2 and ch3 select: 0 clock b, 1 scaled clock upper
// - clock select change may truncate or stretch one pulse
// - start level bits act only in left-aligned mode
// - start level 0: low then high at duty; 1: high then low
// - enable forces pin to output without touching direction bit
// - scaled clock divides by scale value plus one, then by two
module fcp_pwm import fcp_pkg::*; #(
    parameter int NCH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // shared port pins
    input wire logic [NCH-1:0] pin_in,
    output logic [NCH-1:0] pin_out,
    output logic [NCH-1:0] pin_oe
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] clock_join;
        logic [7:0] sel_pol;
        logic [3:0] channel_enable_bits;
        logic [3:0] align_center;
        logic [3:0] port_direction_bits;
        logic [3:0] port_data;
        logic [6:0] prescale;
        logic [7:0] lower_scale_value;
        logic [7:0] upper_scale_value;
        logic [7:0] scnt_lo;
        logic [7:0] scnt_hi;
        logic scaled_clock_lower;
        logic scaled_clock_upper;
        logic [3:0][7:0] count;
        logic [3:0] down;
        logic [3:0][7:0] per_buf;
        logic [3:0][7:0] duty_buf;
        logic [3:0][7:0] per_act;
        logic [3:0][7:0] duty_act;
        logic [3:0] wave;
        logic [7:0] rdata;
        logic [6:0] pre_q;
    } fcp_state_t;

    fcp_state_t s, n;

    // clock a/b tick: prescaler bit toggles low to high, code 0 is every cycle
    function automatic logic fcp_pre_tick(input logic [2:0] code, input logic [6:0] pre, input logic [6:0] pre_q);
        logic t;
        t = 1'b1;
        if (code != 3'd0) begin
            t = pre[code-3'd1] & ~pre_q[code-3'd1];
        end
        return t;
    endfunction : fcp_pre_tick

    logic tick_a, tick_b, tick_s0, tick_s1;
    logic [3:0] ch_tick;
    logic [2:0] code_a, code_b;

    // ==========================================================
    // clock generation
    always_comb begin
        code_a = s.clock_join[FCP_PRESCALE_A_LSB +: 3];
        code_b = s.clock_join[FCP_PRESCALE_B_LSB +: 3];
        tick_a = fcp_pre_tick(code_a, s.prescale, s.pre_q);
        tick_b = fcp_pre_tick(code_b, s.prescale, s.pre_q);
        // scaled clock edge counted once per full wave (rising edge)
        tick_s0 = tick_a && s.scnt_lo == 8'h00 && !s.scaled_clock_lower;
        tick_s1 = tick_b && s.scnt_hi == 8'h00 && !s.scaled_clock_upper;
        for (int i = 0; i < 2; i++) begin
            ch_tick[i] = s.sel_pol[FCP_SCALED_SEL_LSB+i] ? tick_s0 : tick_a;
            ch_tick[i+2] = s.sel_pol[FCP_SCALED_SEL_LSB+i+2] ? tick_s1 : tick_b;
        end
    end

    // joined pair flags: lower pair ch0 and ch1, upper pair ch2 and ch3
    logic join_lo, join_hi;
    assign join_lo = s.clock_join[FCP_JOIN_LOWER_BIT];
    assign join_hi = s.clock_join[FCP_JOIN_UPPER_BIT];

    // ==========================================================
    // next state
    always_comb begin
        logic [3:0] rollover;
        logic [3:0] cnt_wr;
        logic [3:0] act_en;
        logic [15:0] c16, p16, d16;
        n = s;
        rollover = 4'h0;
        cnt_wr = 4'h0;
        act_en = 4'h0;
        c16 = 16'h0000;
        p16 = 16'h0000;
        d16 = 16'h0000;
        n.rdata = FCP_RST_ZERO;
        n.pre_q = s.prescale;
        // prescaler runs only while any channel is enabled, to save power
        if (|s.channel_enable_bits) begin
            n.prescale = s.prescale + 7'd1;
        end
        // scaler counters reload on reaching zero; wave toggles on each reload
        if (tick_a) begin
            if (s.scnt_lo == 8'h00) begin
                n.scnt_lo = s.lower_scale_value;
                n.scaled_clock_lower = ~s.scaled_clock_lower;
            end else begin
                n.scnt_lo = s.scnt_lo - 8'd1;
            end
        end
        if (tick_b) begin
            if (s.scnt_hi == 8'h00) begin
                n.scnt_hi = s.upper_scale_value;
                n.scaled_clock_upper = ~s.scaled_clock_upper;
            end else begin
                n.scnt_hi = s.scnt_hi - 8'd1;
            end
        end
        // joined pairs run from the low channel's clock and enable
        act_en = s.channel_enable_bits;
        if (join_lo) begin
            act_en[0] = s.channel_enable_bits[1];
        end
        if (join_hi) begin
            act_en[2] = s.channel_enable_bits[3];
        end
        // 8-bit channel counters
        for (int i = 0; i < NCH; i++) begin
            if (act_en[i] && ch_tick[i]) begin
                if (!s.align_center[i]) begin
                    if (s.count[i] >= s.per_act[i] - 8'd1 || s.per_act[i] == 8'h00) begin
                        n.count[i] = 8'h00;
                        rollover[i] = 1'b1;
                    end else begin
                        n.count[i] = s.count[i] + 8'd1;
                    end
                end else begin
                    // center aligned: period match turns the count down
                    if (!s.down[i] && s.count[i] >= s.per_act[i]) begin
                        n.down[i] = 1'b1;
                        n.count[i] = s.count[i] - 8'd1;
                    end else if (s.down[i] && s.count[i] <= 8'h01) begin
                        n.down[i] = 1'b0;
                        n.count[i] = 8'h00;
                        rollover[i] = 1'b1;
                    end else begin
                        n.count[i] = s.down[i] ? s.count[i] - 8'd1 : s.count[i] + 8'd1;
                    end
                end
            end
        end
        // 16-bit joined counters overwrite the 8-bit result
        for (int k = 0; k < 2; k++) begin
            if ((k == 0 && join_lo) || (k == 1 && join_hi)) begin
                c16 = {s.count[2*k], s.count[2*k+1]};
                p16 = {s.per_act[2*k], s.per_act[2*k+1]};
                rollover[2*k] = 1'b0;
                rollover[2*k+1] = 1'b0;
                n.count[2*k] = s.count[2*k];
                n.count[2*k+1] = s.count[2*k+1];
                if (act_en[2*k] && ch_tick[2*k+1]) begin
                    if (!s.align_center[2*k]) begin
                        if (c16 >= p16 - 16'd1 || p16 == 16'h0000) begin
                            c16 = 16'h0000;
                            rollover[2*k] = 1'b1;
                        end else begin
                            c16 = c16 + 16'd1;
                        end
                    end else if (!s.down[2*k] && c16 >= p16) begin
                        n.down[2*k] = 1'b1;
                        c16 = c16 - 16'd1;
                    end else if (s.down[2*k] && c16 <= 16'h0001) begin
                        n.down[2*k] = 1'b0;
                        c16 = 16'h0000;
                        rollover[2*k] = 1'b1;
                    end else begin
                        c16 = s.down[2*k] ? c16 - 16'd1 : c16 + 16'd1;
                    end
                    n.count[2*k] = c16[15:8];
                    n.count[2*k+1] = c16[7:0];
                    rollover[2*k+1] = rollover[2*k];
                end
            end
        end
        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                FCP_OFF_CLOCK_JOIN: n.clock_join = reg_wdata;
                FCP_OFF_SEL_POL: n.sel_pol = reg_wdata;
                FCP_OFF_ENABLE: n.channel_enable_bits = reg_wdata[3:0];
                FCP_OFF_SCALE_LO: begin
                    n.lower_scale_value = reg_wdata;
                    n.scnt_lo = reg_wdata;
                end
                FCP_OFF_SCALE_HI: begin
                    n.upper_scale_value = reg_wdata;
                    n.scnt_hi = reg_wdata;
                end
                FCP_OFF_ALIGN: n.align_center = reg_wdata[3:0];
                FCP_OFF_PORT_DIR: n.port_direction_bits = reg_wdata[3:0];
                FCP_OFF_PORT_DATA: n.port_data = reg_wdata[3:0];
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (reg_addr == FCP_OFF_COUNT + 8'(i)) begin
                            cnt_wr[i] = 1'b1;
                        end
                        if (reg_addr == FCP_OFF_PERIOD + 8'(i)) begin
                            n.per_buf[i] = reg_wdata;
                        end
                        if (reg_addr == FCP_OFF_DUTY + 8'(i)) begin
                            n.duty_buf[i] = reg_wdata;
                        end
                    end
                end
            endcase
        end
        // a counter write on either half of a joined pair resets both halves
        if (join_lo && |cnt_wr[1:0]) begin
            cnt_wr[1:0] = 2'b11;
        end
        if (join_hi && |cnt_wr[3:2]) begin
            cnt_wr[3:2] = 2'b11;
        end
        // latch transfer: rollover, disabled, or counter write
        for (int i = 0; i < NCH; i++) begin
            if (cnt_wr[i]) begin
                n.count[i] = 8'h00;
                n.down[i] = 1'b0;
            end
            if (!act_en[i] || cnt_wr[i] || rollover[i]) begin
                n.per_act[i] = n.per_buf[i];
                n.duty_act[i] = n.duty_buf[i];
            end
        end
        // waveform: duty match flips from start level; center ignores start level
        for (int i = 0; i < NCH; i++) begin
            logic lvl;
            lvl = s.align_center[i] ? 1'b0 : s.sel_pol[FCP_START_LEVEL_LSB+i];
            n.wave[i] = (s.count[i] < s.duty_act[i]) ? lvl : ~lvl;
        end
        for (int k = 0; k < 2; k++) begin
            logic lvl;
            c16 = {s.count[2*k], s.count[2*k+1]};
            d16 = {s.duty_act[2*k], s.duty_act[2*k+1]};
            lvl = s.align_center[2*k] ? 1'b0 : s.sel_pol[FCP_START_LEVEL_LSB+2*k];
            if ((k == 0 && join_lo) || (k == 1 && join_hi)) begin
                n.wave[2*k] = (c16 < d16) ? lvl : ~lvl;
            end
        end
        // read mux, data valid the cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                FCP_OFF_CLOCK_JOIN: n.rdata = s.clock_join;
                FCP_OFF_SEL_POL: n.rdata = s.sel_pol;
                FCP_OFF_ENABLE: n.rdata = {4'h0, s.channel_enable_bits};
                FCP_OFF_PRESCALE: n.rdata = {1'b0, s.prescale};
                FCP_OFF_SCALE_LO: n.rdata = s.lower_scale_value;
                FCP_OFF_SCNT_LO: n.rdata = s.scnt_lo;
                FCP_OFF_SCALE_HI: n.rdata = s.upper_scale_value;
                FCP_OFF_SCNT_HI: n.rdata = s.scnt_hi;
                FCP_OFF_ALIGN: n.rdata = {4'h0, s.align_center};
                FCP_OFF_PORT_DIR: n.rdata = {4'h0, s.port_direction_bits};
                FCP_OFF_PORT_DATA: n.rdata = {4'h0, pin_in};
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (reg_addr == FCP_OFF_COUNT + 8'(i)) begin
                            n.rdata = s.count[i];
                        end
                        if (reg_addr == FCP_OFF_PERIOD + 8'(i)) begin
                            n.rdata = s.per_buf[i];
                        end
                        if (reg_addr == FCP_OFF_DUTY + 8'(i)) begin
                            n.rdata = s.duty_buf[i];
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
            for (int i = 0; i < 4; i++) begin
                s.per_buf[i] <= FCP_RST_PERIOD;
                s.per_act[i] <= FCP_RST_PERIOD;
                s.duty_buf[i] <= FCP_RST_DUTY;
                s.duty_act[i] <= FCP_RST_DUTY;
            end
        end else begin
            s <= n;
        end
    end

    // ==========================================================
    // pin mux: joined low channel pins fall back to the port
    always_comb begin
        logic [3:0] pwm_own;
        pwm_own = s.channel_enable_bits;
        if (join_lo) begin
            pwm_own[0] = s.channel_enable_bits[1];
            pwm_own[1] = 1'b0;
        end
        if (join_hi) begin
            pwm_own[2] = s.channel_enable_bits[3];
            pwm_own[3] = 1'b0;
        end
        for (int i = 0; i < NCH; i++) begin
            pin_oe[i] = pwm_own[i] | s.port_direction_bits[i];
            pin_out[i] = pwm_own[i] ? s.wave[i] : s.port_data[i];
        end
    end
    assign reg_rdata = s.rdata;

    // ==========================================================
    // checks
    a_enable_drives: assert property (@(posedge clk) disable iff (!rst_n)
        (!join_lo && !join_hi && s.channel_enable_bits[0]) |-> pin_oe[0]) else $error("enabled pin not driven");
    a_cnt_write_clr: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == FCP_OFF_COUNT) |=> s.count[0] == 8'h00) else $error("counter write did not clear");
    a_dis_direct: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == FCP_OFF_PERIOD && !s.channel_enable_bits[0] && !join_lo)
        |=> s.per_act[0] == $past(reg_wdata)) else $error("disabled write not direct");
    a_en_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (s.channel_enable_bits[0] && !join_lo && !ch_tick[0] && !(reg_wr && reg_addr == FCP_OFF_COUNT))
        |=> $stable(s.per_act[0])) else $error("active period changed mid period");
    a_read_count: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == FCP_OFF_COUNT + 8'h02) |=> reg_rdata == $past(s.count[2])) else $error("count read wrong");
    a_tick_code0: assert property (@(posedge clk) disable iff (!rst_n)
        (code_a == 3'd0) |-> tick_a) else $error("code zero not undivided");
    a_tick_code2: assert property (@(posedge clk) disable iff (!rst_n)
        (code_b == 3'd2 && tick_b) |=> (code_b != 3'd2 || !tick_b)) else $error("clock b divide by four wrong");
    a_join_gpio: assert property (@(posedge clk) disable iff (!rst_n)
        join_hi |-> pin_out[3] == s.port_data[3]) else $error("joined ch3 pin not port");
    a_sel_scaled: assert property (@(posedge clk) disable iff (!rst_n)
        s.sel_pol[FCP_SCALED_SEL_LSB] |-> ch_tick[0] == tick_s0) else $error("ch0 scaled select wrong");
    a_join_lo_pin: assert property (@(posedge clk) disable iff (!rst_n)
        join_lo |-> pin_out[1] == s.port_data[1]) else $error("joined ch1 pin not port");
    c_rollover: cover property (@(posedge clk) disable iff (!rst_n) s.channel_enable_bits[0] && s.count[0] == 8'h00 && $past(s.count[0]) != 8'h00);
    c_join16: cover property (@(posedge clk) disable iff (!rst_n) join_lo && s.count[1] == 8'hff);
    c_center_down: cover property (@(posedge clk) disable iff (!rst_n) s.down[2]);
endmodule : fcp_pwm

`default_nettype wire

// ==== verif/fcp_port_load.sv ====
// partner model: external loads on the shared port pins
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port load model
module fcp_port_load (
    // pins from the block
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // level the outside world puts on a released pin
    input wire logic [3:0] ext_level,
    // levels seen back at the block
    output logic [3:0] pin_in
);
    // a driven pin reads back its own level, a released one shows the outside level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule : fcp_port_load
`default_nettype wire

// ==== verif/tb.sv ====
// testbench: register access, waveform timing and pin ownership of the four channel pwm
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (got), (exp)); end end
// ==========================================
// top
module tb import fcp_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] ext_level = 4'h0;
    logic [7:0] d;
    logic [7:0] d2;
    int n;
    int err_count = 0;
    int checks = 0;
    // left mode table: start level, duty, high cycles out of 40 with period 4
    int tpol[6] = '{0, 1, 0, 0, 1, 1};
    int tduty[6] = '{1, 1, 0, 4, 0, 4};
    int thigh[6] = '{30, 10, 40, 0, 0, 40};

    // 125 MHz clock
    always #4 clk = ~clk;

    fcp_pwm #(.NCH(4)) u_fcp_pwm (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    fcp_port_load u_fcp_port_load (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

    // ==========================================
    // bus and measurement tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // let the edge that takes the write settle before any caller looks at the pins
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // waits for the pin to move to lvl; n+1 is the cycles since the call, capped against hangs
    task automatic wait_edge(input int ch, input logic lvl, output int cnt);
        logic prev;
        cnt = 0;
        prev = pin_out[ch];
        @(negedge clk);
        while (!(prev === ~lvl && pin_out[ch] === lvl) && cnt < 4000) begin
            prev = pin_out[ch];
            cnt++;
            @(negedge clk);
        end
    endtask : wait_edge

    // first rises after a restart may be partial, so only the third interval counts
    task automatic meas(input int ch, input int exp);
        repeat (3) wait_edge(ch, 1'b1, n);
        `CHK(n + 1, exp)
    endtask : meas

    task automatic high_cnt(input int ch, input int win, input int exp);
        int h;
        h = 0;
        repeat (win) begin
            @(negedge clk);
            if (pin_out[ch] === 1'b1) h++;
        end
        `CHK(h, exp)
    endtask : high_cnt

    // stop, clear all counters, enable the given set
    task automatic restart(input logic [7:0] en);
        wr(FCP_OFF_ENABLE, 8'h00);
        for (int i = 0; i < 4; i++) wr(8'(FCP_OFF_COUNT + i), 8'h00);
        wr(FCP_OFF_ENABLE, en);
    endtask : restart

    task automatic end_of_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        #400000;
        err_count++;
        end_of_test();
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(FCP_OFF_CLOCK_JOIN, d); `CHK(d, FCP_RST_ZERO)
        rd(FCP_OFF_SEL_POL, d); `CHK(d, FCP_RST_ZERO)
        rd(FCP_OFF_PERIOD, d); `CHK(d, FCP_RST_PERIOD)
        rd(FCP_OFF_DUTY, d); `CHK(d, FCP_RST_DUTY)
        rd(8'h60, d); `CHK(d, 8'h00)
        `CHK(pin_oe, 4'h0)
        wr(FCP_OFF_CLOCK_JOIN, 8'ha5); rd(FCP_OFF_CLOCK_JOIN, d); `CHK(d, 8'ha5)
        wr(FCP_OFF_SEL_POL, 8'h5a); rd(FCP_OFF_SEL_POL, d); `CHK(d, 8'h5a)
        wr(FCP_OFF_CLOCK_JOIN, 8'h00);
        wr(FCP_OFF_SEL_POL, 8'h00);
        // pins as plain port while no channel is enabled
        ext_level = 4'h6;
        rd(FCP_OFF_PORT_DATA, d); `CHK(d, 8'h06)
        wr(FCP_OFF_PORT_DIR, 8'h0f); wr(FCP_OFF_PORT_DATA, 8'h0a);
        `CHK(pin_out, 4'ha)
        `CHK(pin_oe, 4'hf)
        wr(FCP_OFF_PORT_DIR, 8'h00);
        wr(FCP_OFF_ENABLE, 8'h01);
        `CHK(pin_oe, 4'h1)
        rd(FCP_OFF_PORT_DIR, d); `CHK(d, 8'h00)
        // back-to-back counter reads lie two cycles apart
        rd(FCP_OFF_COUNT, d); rd(FCP_OFF_COUNT, d2); `CHK(8'(d2 - d), 8'h02)
        wr(FCP_OFF_ENABLE, 8'h00); wr(FCP_OFF_COUNT, 8'h33);
        rd(FCP_OFF_COUNT, d); `CHK(d, 8'h00)
        wr(FCP_OFF_PERIOD, 8'h04);
        rd(FCP_OFF_PERIOD, d); `CHK(d, 8'h04)
        // left-aligned start levels and duty extremes, period 4, written while disabled
        for (int i = 0; i < 6; i++) begin
            wr(FCP_OFF_ENABLE, 8'h00);
            wr(FCP_OFF_SEL_POL, 8'(tpol[i]));
            wr(FCP_OFF_DUTY, 8'(tduty[i]));
            restart(8'h01);
            repeat (8) @(negedge clk);
            high_cnt(0, 40, thigh[i]);
        end
        // every clock a prescale code
        wr(FCP_OFF_SEL_POL, 8'h00);
        wr(FCP_OFF_ENABLE, 8'h00);
        wr(FCP_OFF_DUTY, 8'h02);
        for (int c = 0; c < 8; c++) begin
            wr(FCP_OFF_CLOCK_JOIN, 8'(c << 3));
            restart(8'h01);
            meas(0, 4 << c);
        end
        wr(FCP_OFF_CLOCK_JOIN, 8'h00);
        wr(FCP_OFF_SEL_POL, 8'h10);
        wr(FCP_OFF_SCALE_LO, 8'h00); restart(8'h01); meas(0, 8);
        wr(FCP_OFF_SCALE_LO, 8'h01); restart(8'h01); meas(0, 16);
        // center aligned: one rise per up and down sweep
        wr(FCP_OFF_SEL_POL, 8'h00);
        wr(FCP_OFF_ALIGN, 8'h01); restart(8'h01); meas(0, 8);
        wr(FCP_OFF_ENABLE, 8'h00); wr(FCP_OFF_SEL_POL, 8'h01); wr(FCP_OFF_DUTY, 8'h00);
        restart(8'h01); repeat (8) @(negedge clk); high_cnt(0, 40, 40);
        wr(FCP_OFF_ALIGN, 8'h00);
        wr(FCP_OFF_SEL_POL, 8'h00);
        // clock b on channel 2, then the upper scaled clock
        wr(8'(FCP_OFF_PERIOD + 2), 8'h04); wr(8'(FCP_OFF_DUTY + 2), 8'h02);
        wr(FCP_OFF_CLOCK_JOIN, 8'h02); restart(8'h04); meas(2, 16);
        rd(8'(FCP_OFF_COUNT + 2), d); `CHK(d < 8'h04, 1'b1)
        wr(FCP_OFF_SEL_POL, 8'h40);
        wr(FCP_OFF_SCALE_HI, 8'h00); restart(8'h04); meas(2, 32);
        // lower pair joined: 16-bit period 6 on pin 0, odd pin back to the port
        wr(FCP_OFF_ENABLE, 8'h00); wr(FCP_OFF_SEL_POL, 8'h00);
        wr(FCP_OFF_PERIOD, 8'h00); wr(8'(FCP_OFF_PERIOD + 1), 8'h06);
        wr(FCP_OFF_DUTY, 8'h00); wr(8'(FCP_OFF_DUTY + 1), 8'h03);
        wr(FCP_OFF_CLOCK_JOIN, 8'h40); restart(8'h02);
        `CHK(pin_oe, 4'h1)
        meas(0, 6);
        // upper pair joined
        wr(FCP_OFF_ENABLE, 8'h00);
        wr(8'(FCP_OFF_PERIOD + 2), 8'h00); wr(8'(FCP_OFF_PERIOD + 3), 8'h06);
        wr(8'(FCP_OFF_DUTY + 2), 8'h00); wr(8'(FCP_OFF_DUTY + 3), 8'h03);
        wr(FCP_OFF_CLOCK_JOIN, 8'h80); restart(8'h08);
        `CHK(pin_oe, 4'h4)
        meas(2, 6);
        // slow clock so a buffered write is visible for hundreds of cycles
        wr(FCP_OFF_ENABLE, 8'h00); wr(FCP_OFF_CLOCK_JOIN, 8'h38);
        wr(FCP_OFF_PERIOD, 8'h04); wr(FCP_OFF_DUTY, 8'h02); restart(8'h01);
        wait_edge(0, 1'b0, n);
        wr(FCP_OFF_DUTY, 8'h00);
        repeat (100) @(negedge clk);
        `CHK(pin_out[0], 1'b0)
        wait_edge(0, 1'b1, n);
        wr(FCP_OFF_DUTY, 8'h04); wr(FCP_OFF_COUNT, 8'h00);
        repeat (4) @(negedge clk);
        `CHK(pin_out[0], 1'b0)
        end_of_test();
    end
endmodule : tb
`default_nettype wire
